// ---- logic/scabs_consts.vh ----
`ifndef SCABS_CONSTS_VH
`define SCABS_CONSTS_VH
// command word field positions on the bus
`define SCABS_CMD_B15      15
`define SCABS_CMD_B14      14
`define SCABS_CMD_B13      13
`define SCABS_CMD_B12      12
`define SCABS_CMD_B11      11
`define SCABS_CMD_B10      10
// run lengths in converter clock cycles
`define SCABS_CAL_CYCLES   9'h12c
`define SCABS_CONV_CYCLES  9'h018
// sampling window within a conversion
`define SCABS_SAMP_FIRST   9'h003
`define SCABS_SAMP_LAST    9'h00a
// result layout
`define SCABS_RES_W        13
`define SCABS_SIGN_BIT     12
`define SCABS_BUS_W        16
// converter clock divider default: 100 MHz / 50 = 2 MHz
`define SCABS_CLK_DIV      8'h32
`define SCABS_READY_WAIT   4'h2
`endif

// ---- logic/scabs_sar_core.v ----
`timescale 1ns/1ps
`include "scabs_consts.vh"
// digital stand-in for the successive approximation engine:
// tracks the input while sampling, then copies the held value to the output on each later step
module scabs_sar_core
#(
  parameter RES_W = `SCABS_RES_W // result width
)
(
  input  wire             i_clk_sys, // system clock
  input  wire             i_reset,   // sync reset, active high
  input  wire             i_tick,    // converter clock step
  input  wire             i_sample,  // track the input
  input  wire             i_start,   // new run begins
  input  wire [RES_W-1:0] i_ain,     // digitised differential input
  output reg  [RES_W-1:0] o_code     // held approximation
);
  reg [RES_W-1:0] held_r; // value held after sampling
  // hold input: follows only while sampling
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      held_r <= {RES_W{1'b0}};
      o_code <= {RES_W{1'b0}};
    end
    else if (i_start)
      o_code <= {RES_W{1'b0}};
    else if (i_tick)
    begin
      if (i_sample)
        held_r <= i_ain;
      else
        o_code <= held_r; // input stays held after window
    end
  end
endmodule

// ---- logic/scabs_seq.v ----
`timescale 1ns/1ps
`include "scabs_consts.vh"
module scabs_seq
#(
  parameter [7:0] CLK_DIV = `SCABS_CLK_DIV,    // system clocks per converter clock
  parameter [3:0] RDY_WT  = `SCABS_READY_WAIT  // wait states per access
)
(
  input  wire                     i_clk_sys,   // system clock
  input  wire                     i_reset,     // sync reset, active high
  input  wire                     i_cs_n,      // chip select, active low
  input  wire                     i_wr_n,      // write strobe, active low
  input  wire                     i_rd_n,      // read strobe, active low
  input  wire                     i_conv_clk_en, // converter clock running
  input  wire [`SCABS_BUS_W-1:0]  i_data,      // bus data in
  input  wire [`SCABS_RES_W-1:0]  i_ain,       // digitised differential input
  output reg  [`SCABS_BUS_W-1:0]  o_data,      // bus data out
  output wire                     o_data_oe,   // bus drive enable
  output reg                      o_int_n,     // completion interrupt, active low
  output wire                     o_ready,     // ready, low inserts wait
  output wire                     o_busy,      // run in progress
  output wire                     o_calibrating, // calibration run active
  output wire                     o_cal_valid, // calibration data valid
  output wire                     o_sampling   // input sampling window
);
  localparam [2:0] ST_IDLE = 3'b001; // waiting for command
  localparam [2:0] ST_CONV = 3'b010; // conversion run
  localparam [2:0] ST_CAL  = 3'b100; // calibration run

  reg  [2:0]                state_r;    // run state
  reg  [2:0]                state_nxt;  // next run state
  reg  [8:0]                cyc_r;      // converter cycle number in run
  reg  [8:0]                cyc_nxt;    // next cycle number
  reg  [7:0]                div_r;      // converter clock divider
  reg                       up_r;       // first converter cycle elapsed
  reg                       cal_ok_r;   // calibration data held
  reg  [`SCABS_BUS_W-1:0]   cmd_r;      // captured bus word
  reg  [`SCABS_RES_W-1:0]   res_r;      // output latch
  reg                       int_period_r; // interrupt fell this period
  reg                       rd_hold_r;  // early read seen: only a write clears
  reg  [3:0]                wait_r;     // wait state counter
  wire                      tick;       // converter clock step
  wire                      wr_act;     // write condition active
  wire                      wr_fall;    // write condition begins
  wire                      wr_rise;    // write condition ends: latch
  wire                      rd_act;     // read condition active
  wire                      rd_fall;    // read condition begins
  wire                      go_conv;    // conversion command taken
  wire                      go_cal;     // calibration command taken
  wire                      conv_done;  // last conversion cycle ends
  wire [`SCABS_RES_W-1:0]   code;       // engine result

  // command decode, shared by the capture path
  function is_conv;
    input [`SCABS_BUS_W-1:0] w;
    begin
      is_conv = w[`SCABS_CMD_B15] & ~w[`SCABS_CMD_B14] & ~w[`SCABS_CMD_B10];
    end
  endfunction

  function is_cal;
    input [`SCABS_BUS_W-1:0] w;
    begin
      is_cal = ~w[`SCABS_CMD_B15] & ~w[`SCABS_CMD_B13] & ~w[`SCABS_CMD_B12]
             & ~w[`SCABS_CMD_B11] & ~w[`SCABS_CMD_B10];
    end
  endfunction

  // sign extension of the result to the bus
  function [`SCABS_BUS_W-1:0] sext;
    input [`SCABS_RES_W-1:0] r;
    begin
      sext = {{(`SCABS_BUS_W-`SCABS_RES_W){r[`SCABS_SIGN_BIT]}}, r};
    end
  endfunction

  scabs_strobe_edge u_wr
  (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_cs_n    (i_cs_n),
    .i_stb_n   (i_wr_n),
    .o_active  (wr_act),
    .o_fall    (wr_fall),
    .o_rise    (wr_rise)
  );

  scabs_strobe_edge u_rd
  (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_cs_n    (i_cs_n),
    .i_stb_n   (i_rd_n),
    .o_active  (rd_act),
    .o_fall    (rd_fall),
    .o_rise    ()
  );

  // converter clock divider; clears to zero when the clock is stopped
  always @(posedge i_clk_sys)
  begin
    if (i_reset || !i_conv_clk_en)
      div_r <= 8'h00;
    else if (div_r == CLK_DIV - 8'h01)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end
  assign tick = i_conv_clk_en && (div_r == CLK_DIV - 8'h01);

  // capture the bus word while the write condition holds
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
      cmd_r <= {`SCABS_BUS_W{1'b0}};
    else if (wr_act)
      cmd_r <= i_data;
  end

  // commands only after first converter cycle since power-up
  assign go_conv = wr_rise & up_r & is_conv(cmd_r);
  assign go_cal  = wr_rise & up_r & is_cal(cmd_r);

  // power-up flag: set by first converter cycle
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
      up_r <= 1'b0;
    else if (tick)
      up_r <= 1'b1;
  end

  // run state machine
  always @*
  begin
    state_nxt = state_r;
    cyc_nxt   = cyc_r;
    if (go_cal)
    begin
      state_nxt = ST_CAL;
      cyc_nxt   = 9'h001;
    end
    else if (go_conv)
    begin
      state_nxt = ST_CONV;
      cyc_nxt   = 9'h001;
    end
    else if (tick)
    begin
      case (state_r)
        ST_CONV:
        begin
          if (cyc_r == `SCABS_CONV_CYCLES)
          begin
            state_nxt = ST_IDLE;
            cyc_nxt   = 9'h000;
          end
          else
            cyc_nxt = cyc_r + 9'h001;
        end
        ST_CAL:
        begin
          if (cyc_r == `SCABS_CAL_CYCLES)
          begin
            state_nxt = ST_IDLE;
            cyc_nxt   = 9'h000;
          end
          else
            cyc_nxt = cyc_r + 9'h001;
        end
        default:
          cyc_nxt = 9'h000;
      endcase
    end
  end

  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_r <= ST_IDLE;
      cyc_r   <= 9'h000;
    end
    else
    begin
      state_r <= state_nxt;
      cyc_r   <= cyc_nxt;
    end
  end

  assign conv_done = tick && state_r == ST_CONV && cyc_r == `SCABS_CONV_CYCLES;
  assign o_sampling = state_r == ST_CONV && cyc_r >= `SCABS_SAMP_FIRST
                      && cyc_r <= `SCABS_SAMP_LAST;
  assign o_busy        = state_r != ST_IDLE;
  assign o_calibrating = state_r == ST_CAL;

  scabs_sar_core #(.RES_W(`SCABS_RES_W)) u_core
  (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_tick    (tick),
    .i_sample  (o_sampling),
    .i_start   (go_conv),
    .i_ain     (i_ain),
    .o_code    (code)
  );

  // calibration validity; a stopped clock drops it
  always @(posedge i_clk_sys)
  begin
    if (i_reset || !i_conv_clk_en)
      cal_ok_r <= 1'b0;
    else if (go_conv || go_cal)
      cal_ok_r <= cal_ok_r & ~go_cal; // recalibration in progress
    else if (tick && state_r == ST_CAL && cyc_r == `SCABS_CAL_CYCLES)
      cal_ok_r <= 1'b1;
  end
  assign o_cal_valid = cal_ok_r;

  // result latch at completion
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
      res_r <= {`SCABS_RES_W{1'b0}};
    else if (conv_done)
      res_r <= code;
  end

  // interrupt: completion sets low, write strobe clears, read strobe clears unless early or locked out; set wins
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_int_n      <= 1'b1;
      int_period_r <= 1'b0;
    end
    else
    begin
      if (conv_done)
        o_int_n <= 1'b0;
      else if (wr_fall)
        o_int_n <= 1'b1;
      else if (rd_fall && !int_period_r && !rd_hold_r)
        o_int_n <= 1'b1;
      // remember the period in which the interrupt fell
      if (conv_done)
        int_period_r <= 1'b1;
      else if (tick)
        int_period_r <= 1'b0;
    end
  end

  // a read that meets the interrupt in its own period locks out
  // every later read; the host must write to clear the interrupt
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
      rd_hold_r <= 1'b0;
    else if (rd_fall && (conv_done || int_period_r))
      rd_hold_r <= 1'b1;
    else if (wr_fall)
      rd_hold_r <= 1'b0;
  end

  // read data from flip-flops, driven only during read
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_data <= {`SCABS_BUS_W{1'b0}};
    else
      o_data <= sext(res_r);
  end
  assign o_data_oe = rd_act;

  // ready: hold low for a few clocks at each access start
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
      wait_r <= 4'h0;
    else if (rd_fall || wr_fall)
      wait_r <= RDY_WT;
    else if (wait_r != 4'h0)
      wait_r <= wait_r - 4'h1;
  end
  assign o_ready = (wait_r == 4'h0) & ~(rd_fall | wr_fall);
endmodule

// ---- logic/scabs_strobe_edge.v ----
`timescale 1ns/1ps
`include "scabs_consts.vh"
// watches a combined chip-select and strobe low condition
module scabs_strobe_edge
(
  input  wire i_clk_sys, // system clock
  input  wire i_reset,   // sync reset, active high
  input  wire i_cs_n,    // chip select, active low
  input  wire i_stb_n,   // read or write strobe, active low
  output wire o_active,  // both low now
  output wire o_fall,    // condition just began
  output wire o_rise     // condition just ended
);
  reg act_r; // previous condition
  assign o_active = ~i_cs_n & ~i_stb_n;
  // edge detect; inputs are already synchronous
  always @(posedge i_clk_sys)
  begin
    if (i_reset)
      act_r <= 1'b0;
    else
      act_r <= o_active;
  end
  assign o_fall = o_active & ~act_r;
  assign o_rise = ~o_active & act_r;
endmodule

// ---- verification/scabs_host_bfm.sv ----
`timescale 1ns/1ps
// host cpu on the parallel bus
module scabs_host_bfm
(
  input  wire        i_clk_sys,              // clock
  input  wire        i_ready,                // device ready
  input  wire        i_oe,                   // device drives bus
  input  wire [15:0] i_rdata,                // device bus out
  output reg         o_cs_n = 1'b1,          // select
  output reg         o_wr_n = 1'b1,          // write strobe
  output reg         o_rd_n = 1'b1,          // read strobe
  output reg  [15:0] o_data = 16'h5a5a       // command word
);
  integer n; // wait guard
  // one bus cycle, held until ready is seen high at an edge
  task acc(input is_wr, input [15:0] w, output [15:0] r);
    @(posedge i_clk_sys);
    #1 o_cs_n = 1'b0;
    o_wr_n = !is_wr;
    o_rd_n = is_wr;
    o_data = w;
    @(posedge i_clk_sys);
    for (n = 0; n < 32 && i_ready !== 1'b1; n = n + 1) @(posedge i_clk_sys);
    r = i_oe ? i_rdata : 16'hxxxx; // undriven bus reads as unknown
    #1 o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_data = ~w; // no stale word left behind
  endtask
endmodule

// ---- verification/scabs_seq_asserts.sv ----
`timescale 1ns/1ps
// port-level checks on the bus sequencer
module scabs_seq_asserts
#(parameter [7:0] CLK_DIV = 8'h08) // clocks per converter tick
(
  input wire i_clk_sys,     // clock
  input wire i_reset,       // sync reset
  input wire i_cs_n,        // select
  input wire i_wr_n,        // write strobe
  input wire i_rd_n,        // read strobe
  input wire i_conv_clk_en, // tick enable
  input wire o_data_oe,     // bus drive
  input wire o_int_n,       // completion
  input wire o_ready,       // wait control
  input wire o_busy,        // run active
  input wire o_calibrating, // cal run
  input wire o_cal_valid,   // cal good
  input wire o_sampling     // sample window
);
  wire       wr_act = !i_cs_n && !i_wr_n; // write pair low
  wire       rd_act = !i_cs_n && !i_rd_n; // read pair low
  reg [15:0] wr_r;  // clocks since write pair
  reg [15:0] smp_r; // clocks in sample window
  reg [15:0] int_r; // clocks with int low
  // write and interrupt ages saturate so long idle spans never wrap
  always @(posedge i_clk_sys)
  begin
    wr_r  <= (i_reset || wr_act) ? 16'h0000 : wr_r + {15'h0000, ~&wr_r};
    smp_r <= (i_reset || !o_sampling) ? 16'h0000 : smp_r + 16'h0001;
    int_r <= (i_reset || o_int_n) ? 16'h0000 : int_r + {15'h0000, ~&int_r};
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_oe; o_data_oe == rd_act; endproperty
  a_oe: assert property (p_oe) else $error("bus drive wrong");
  property p_rdy; $rose(wr_act || rd_act) |-> !o_ready [*3] ##1 o_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("wait states wrong");
  property p_go; $rose(o_busy) |-> wr_r <= 3; endproperty
  a_go: assert property (p_go) else $error("run without command");
  property p_cv; $fell(o_int_n) |-> wr_r >= 23*CLK_DIV && wr_r <= 24*CLK_DIV+6; endproperty
  a_cv: assert property (p_cv) else $error("conversion length wrong");
  property p_cal; $fell(o_calibrating) && !o_busy |-> wr_r >= 299*CLK_DIV; endproperty
  a_cal: assert property (p_cal) else $error("calibration too short");
  property p_smp; $fell(o_sampling) && wr_r > 8 |-> smp_r == 8*CLK_DIV; endproperty
  a_smp: assert property (p_smp) else $error("sample window wrong");
  property p_keep; $rose(rd_act) && !o_int_n && int_r <= 2 |-> ##3 !o_int_n; endproperty
  a_keep: assert property (p_keep) else $error("early read cleared int");
  property p_stop; !i_conv_clk_en |=> !o_cal_valid; endproperty
  a_stop: assert property (p_stop) else $error("cal kept after stop");
  c_int: cover property ($fell(o_int_n));
  c_cal: cover property ($rose(o_cal_valid));
  c_keep: cover property ($rose(rd_act) && !o_int_n && int_r <= 2);
endmodule
bind scabs_seq scabs_seq_asserts #(.CLK_DIV(CLK_DIV)) u_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cs_n(i_cs_n), .i_wr_n(i_wr_n),
  .i_rd_n(i_rd_n), .i_conv_clk_en(i_conv_clk_en), .o_data_oe(o_data_oe), .o_int_n(o_int_n),
  .o_ready(o_ready), .o_busy(o_busy), .o_calibrating(o_calibrating),
  .o_cal_valid(o_cal_valid), .o_sampling(o_sampling));

// ---- verification/scabs_seq_tb.sv ----
`timescale 1ns/1ps
module scabs_seq_tb;
  reg         clk = 1'b0, rst, clk_en; // clock, reset, tick enable
  reg  [12:0] ain, a;                  // input code, expected code
  wire        cs_n, wr_n, rd_n, oe;    // bus controls
  wire        int_n, ready, busy, cal, cal_ok; // status
  wire [15:0] wdata, rdata;            // bus words
  integer     seed, err_total, check_count, i, n; // bench state
  reg  [31:0] rw;                      // random word
  reg  [15:0] got;                     // read back
  scabs_seq #(.CLK_DIV(8'h08), .RDY_WT(4'h2)) uut (
    .i_clk_sys(clk), .i_reset(rst), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
    .i_conv_clk_en(clk_en), .i_data(wdata), .i_ain(ain), .o_data(rdata), .o_data_oe(oe),
    .o_int_n(int_n), .o_ready(ready), .o_busy(busy), .o_calibrating(cal),
    .o_cal_valid(cal_ok), .o_sampling());
  scabs_host_bfm u_host (.i_clk_sys(clk), .i_ready(ready), .i_oe(oe), .i_rdata(rdata),
    .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n), .o_data(wdata));
  initial forever #5 clk = ~clk;
  function [15:0] sext(input [12:0] v); // sign copied upward
    sext = {{3{v[12]}}, v};
  endfunction
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    check_count = check_count + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("BAD %0s exp %h got %h", nm, e, g);
    end
  endtask
  task chkb(input [63:0] nm, input e, input g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // conversion; input moved once the sample window has closed
  task conv(input [12:0] v, input fast);
    @(posedge clk);
    #1 ain = v;
    rw = $random(seed);
    u_host.acc(1'b1, {2'b10, rw[2:0], 1'b0, rw[12:3]}, got);
    repeat (100) @(posedge clk);
    #1 ain = ~v;
    for (n = 0; n < 300 && int_n !== 1'b0; n = n + 1) @(posedge clk);
    chkb("int_lo", 1'b0, int_n);
    if (!fast)
      repeat (20) @(posedge clk);
    u_host.acc(1'b0, 16'h0000, got);
    chk("result", sext(v), got);
    repeat (3) @(posedge clk);
    chkb("int_rd", !fast, int_n);
    // after an early read, a later read must not clear either
    if (fast)
    begin
      repeat (20) @(posedge clk);
      u_host.acc(1'b0, 16'h0000, got);
      repeat (3) @(posedge clk);
      chkb("int_hold", 1'b0, int_n);
    end
  endtask
  initial
  begin
    seed = 32'h3a9c;
    err_total = 0;
    check_count = 0;
    clk_en = 1'b1;
    ain = 13'h0000;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    repeat (40) @(posedge clk);
    chkb("idle", 1'b0, busy);
    chkb("cal_rst", 1'b0, cal_ok);
    $display("test reset done");
    for (i = 0; i < 8; i = i + 1)
    begin
      rw = $random(seed);
      a = (i == 0) ? 13'h0fff : (i == 1) ? 13'h1000 : (i == 2) ? 13'h1fff : rw[12:0];
      conv(a, i == 7);
    end
    u_host.acc(1'b1, 16'h7c00, got);
    repeat (3) @(posedge clk);
    chkb("int_wr", 1'b1, int_n);
    chkb("refuse", 1'b0, busy);
    $display("test convert done");
    u_host.acc(1'b1, 16'h8000, got);
    repeat (100) @(posedge clk);
    conv(13'h0555, 1'b0);
    u_host.acc(1'b1, 16'h8000, got);
    repeat (20) @(posedge clk);
    rw = $random(seed);
    u_host.acc(1'b1, {1'b0, rw[0], 4'h0, rw[10:1]}, got);
    repeat (3) @(posedge clk);
    chkb("cal_on", 1'b1, cal);
    for (n = 0; n < 2600 && busy !== 1'b0; n = n + 1) @(posedge clk);
    @(posedge clk);
    chkb("cal_ok", 1'b1, cal_ok);
    $display("test restart done");
    #1 clk_en = 1'b0;
    repeat (10) @(posedge clk);
    chkb("cal_lost", 1'b0, cal_ok);
    $display("test clock stop done");
    wrap_up;
  end
  // hang guard, well past the expected run length
  initial
  begin
    #200000;
    err_total = err_total + 1;
    $display("BAD watchdog exp done got hang");
    wrap_up;
  end
endmodule
